// ### rtl/usb_host_config_header_regs.sv
// configuration header registers of the three usb host functions, with sof timing
`timescale 1ns/10ps
// ==========================================================
module usb_host_config_header_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // avalon-mm register slave
  input wire usb_cfg_pkg::avalon_req_type bus_req,
  output usb_cfg_pkg::avalon_rsp_type bus_rsp,
  // strap default loader
  input wire usb_cfg_pkg::strap_load_type strap,
  input wire logic strap_done,
  // frame timing
  output logic sof_strobe,
  output logic [5:0] frame_length_adjust
);

  // ==========================================================
  // state
  typedef struct packed {
    usb_cfg_pkg::bus_state_type bus;
    logic waitreq;
    logic [usb_cfg_pkg::DATA_W-1:0] rdata;
    logic [usb_cfg_pkg::NUM_FUNC-1:0][15:0] subsys;
    logic [usb_cfg_pkg::NUM_FUNC-1:0][7:0] cap;
    logic [usb_cfg_pkg::NUM_FUNC-1:0][7:0] line;
    logic [usb_cfg_pkg::FLA_W-1:0] fla;
  } cfg_state_type;

  localparam cfg_state_type STATE_RESET = '{
    bus: usb_cfg_pkg::BUS_LOAD,
    waitreq: 1'b1,
    rdata: '0,
    subsys: {usb_cfg_pkg::SUBSYS_HS_RESET, usb_cfg_pkg::SUBSYS_FS_RESET,
             usb_cfg_pkg::SUBSYS_FS_RESET},
    cap: {3{usb_cfg_pkg::CAP_RESET}},
    line: {3{usb_cfg_pkg::IRQ_LINE_RESET}},
    fla: usb_cfg_pkg::FLA_RESET
  };

  cfg_state_type state;
  cfg_state_type next_state;
  logic [1:0] fn;
  logic [7:0] off;
  logic fn_ok;

  // ==========================================================
  // read mux
  // unmapped offsets and the fourth function slot read as zero
  function automatic logic [31:0] read_word(input logic [1:0] f, input logic [7:0] o,
                                            input cfg_state_type s);
    logic [31:0] w;
    w = '0;
    if (f <= usb_cfg_pkg::FUNC_HS) begin
      case (o)
        usb_cfg_pkg::OFF_HDR: begin
          w[usb_cfg_pkg::HDR_LSB +: 8] = usb_cfg_pkg::HDR_TYPE;
        end
        usb_cfg_pkg::OFF_SUBSYS: begin
          w[usb_cfg_pkg::SUBSYS_LSB +: 16] = s.subsys[f];
        end
        usb_cfg_pkg::OFF_CAP: begin
          w[7:0] = s.cap[f];
        end
        usb_cfg_pkg::OFF_IRQ: begin
          w[7:0] = s.line[f];
          w[usb_cfg_pkg::PIN_LSB +: 8] = usb_cfg_pkg::PIN_BASE + {6'h00, f};
        end
        usb_cfg_pkg::OFF_USB: begin
          if (f == usb_cfg_pkg::FUNC_HS) begin
            w[7:0] = usb_cfg_pkg::USB_REL;
            w[usb_cfg_pkg::FLA_LSB +: usb_cfg_pkg::FLA_W] = s.fla;
          end
        end
        default: begin
          w = '0;
        end
      endcase
    end
    return w;
  endfunction : read_word

  // ==========================================================
  // next state
  assign fn = bus_req.address[usb_cfg_pkg::FUNC_MSB:usb_cfg_pkg::FUNC_LSB];
  assign off = {bus_req.address[usb_cfg_pkg::OFF_MSB:usb_cfg_pkg::WORD_LSB], 2'b00};
  assign fn_ok = (fn <= usb_cfg_pkg::FUNC_HS);

  always_comb begin
    next_state = state;
    next_state.waitreq = 1'b1;
    // strap loader may rewrite read-only defaults at any time
    for (int f = 0; f < usb_cfg_pkg::NUM_FUNC; f++) begin
      if (strap.valid && strap.func == 2'(f)) begin
        if (strap.field == usb_cfg_pkg::STRAP_SUBSYS) begin
          next_state.subsys[f] = strap.data;
        end else begin
          next_state.cap[f] = strap.data[7:0];
        end
      end
    end
    unique case (state.bus)
      usb_cfg_pkg::BUS_LOAD: begin
        // host accesses stall until the loader reports its defaults in place
        if (strap_done) begin
          next_state.bus = usb_cfg_pkg::BUS_IDLE;
        end
      end
      usb_cfg_pkg::BUS_IDLE: begin
        if (bus_req.read || bus_req.write) begin
          next_state.bus = usb_cfg_pkg::BUS_ACK;
          next_state.waitreq = 1'b0;
          next_state.rdata = bus_req.read ? read_word(fn, off, state) : '0;
          if (bus_req.write && fn_ok && off == usb_cfg_pkg::OFF_IRQ &&
              bus_req.byteenable[usb_cfg_pkg::BE_LINE]) begin
            next_state.line[fn] = bus_req.writedata[7:0];
          end
          if (bus_req.write && fn == usb_cfg_pkg::FUNC_HS && off == usb_cfg_pkg::OFF_USB &&
              bus_req.byteenable[usb_cfg_pkg::BE_FLA]) begin
            next_state.fla =
              bus_req.writedata[usb_cfg_pkg::FLA_LSB +: usb_cfg_pkg::FLA_W];
          end
        end
      end
      usb_cfg_pkg::BUS_ACK: begin
        // one idle cycle so a held request is not taken twice
        next_state.bus = usb_cfg_pkg::BUS_IDLE;
      end
      default: begin
        next_state.bus = usb_cfg_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign bus_rsp.waitrequest = state.waitreq;
  assign bus_rsp.readdata = state.rdata;
  assign frame_length_adjust = state.fla;

  sof_period_counter u_sof (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .frame_adjust(state.fla),
    .sof(sof_strobe)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_accept;
    state.bus == usb_cfg_pkg::BUS_IDLE && (bus_req.read || bus_req.write);
  endsequence

  sequence s_answer;
    !bus_rsp.waitrequest ##1 bus_rsp.waitrequest;
  endsequence

  sequence s_read_done;
    bus_req.read && !bus_rsp.waitrequest && fn_ok;
  endsequence

  a_accept_answer: assert property (s_accept |=> s_answer)
    else $error("request not answered in one cycle");

  a_ack_single: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
    else $error("acknowledge held for more than one cycle");

  a_write_rdata: assert property ((s_accept ##0 bus_req.write) |=> bus_rsp.readdata == '0)
    else $error("read data not cleared by a write");

  a_load_blocks: assert property (
    state.bus == usb_cfg_pkg::BUS_LOAD |-> bus_rsp.waitrequest)
    else $error("access completed before defaults loaded");

  a_load_leave: assert property (
    (state.bus == usb_cfg_pkg::BUS_LOAD && strap_done) |=>
      state.bus == usb_cfg_pkg::BUS_IDLE)
    else $error("loader completion not honoured");

  a_subsys_read: assert property (
    (s_read_done and (off == usb_cfg_pkg::OFF_SUBSYS)) |->
      bus_rsp.readdata[31:16] == $past(state.subsys[fn]))
    else $error("subsystem identifier read wrong");

  a_subsys_strap: assert property (
    (strap.valid && strap.field == usb_cfg_pkg::STRAP_SUBSYS &&
     strap.func <= usb_cfg_pkg::FUNC_HS) |=>
      state.subsys[$past(strap.func)] == $past(strap.data))
    else $error("subsystem identifier not loaded");

  a_subsys_reset: assert property (
    $past(!rst_n) |->
      (state.subsys[0] == usb_cfg_pkg::SUBSYS_FS_RESET &&
       state.subsys[1] == usb_cfg_pkg::SUBSYS_FS_RESET &&
       state.subsys[usb_cfg_pkg::FUNC_HS] == usb_cfg_pkg::SUBSYS_HS_RESET))
    else $error("subsystem identifier reset wrong");

  a_cap_reset: assert property (
    $past(!rst_n) |-> state.cap[0] == usb_cfg_pkg::CAP_RESET)
    else $error("capability pointer reset wrong");

  a_cap_strap: assert property (
    (strap.valid && strap.field == usb_cfg_pkg::STRAP_CAP &&
     strap.func <= usb_cfg_pkg::FUNC_HS) |=>
      state.cap[$past(strap.func)] == $past(strap.data[7:0]))
    else $error("capability pointer not loaded");

  a_strap_drop: assert property (
    (strap.valid && strap.func == 2'h3) |=>
      ($stable(state.cap) && $stable(state.subsys)))
    else $error("strap load to the empty function slot took effect");

  a_cap_read: assert property (
    (s_read_done and (off == usb_cfg_pkg::OFF_CAP)) |->
      bus_rsp.readdata[7:0] == $past(state.cap[fn]))
    else $error("capability pointer read wrong");

  a_line_reset: assert property (
    $past(!rst_n) |-> state.line[1] == usb_cfg_pkg::IRQ_LINE_RESET)
    else $error("interrupt routing byte reset wrong");

  a_line_write: assert property (
    (s_accept ##0 (bus_req.write && fn_ok && off == usb_cfg_pkg::OFF_IRQ &&
     bus_req.byteenable[usb_cfg_pkg::BE_LINE])) |=>
      state.line[$past(fn)] == $past(bus_req.writedata[7:0]))
    else $error("interrupt routing byte not stored");

  a_line_lane: assert property (
    (s_accept ##0 (bus_req.write && fn_ok && off == usb_cfg_pkg::OFF_IRQ &&
     !bus_req.byteenable[usb_cfg_pkg::BE_LINE])) |=>
      state.line[$past(fn)] == $past(state.line[fn]))
    else $error("interrupt routing byte written through a disabled lane");

  a_line_read: assert property (
    (s_read_done and (off == usb_cfg_pkg::OFF_IRQ)) |->
      bus_rsp.readdata[7:0] == $past(state.line[fn]))
    else $error("interrupt routing byte read wrong");

  a_pin_read: assert property (
    (s_read_done and (off == usb_cfg_pkg::OFF_IRQ)) |->
      bus_rsp.readdata[15:8] == usb_cfg_pkg::PIN_BASE + {6'h00, fn})
    else $error("interrupt pin code wrong");

  a_release_read: assert property (
    (s_read_done and (off == usb_cfg_pkg::OFF_USB)) |->
      bus_rsp.readdata[7:0] ==
        ((fn == usb_cfg_pkg::FUNC_HS) ? usb_cfg_pkg::USB_REL : 8'h00))
    else $error("usb release number wrong");

  a_fla_write: assert property (
    (s_accept ##0 (bus_req.write && fn == usb_cfg_pkg::FUNC_HS &&
     off == usb_cfg_pkg::OFF_USB && bus_req.byteenable[usb_cfg_pkg::BE_FLA])) |=>
      frame_length_adjust == $past(bus_req.writedata[13:8]))
    else $error("frame length adjustment not stored");

  a_fla_guard: assert property (
    (s_accept ##0 (bus_req.write && fn != usb_cfg_pkg::FUNC_HS)) |=>
      $stable(frame_length_adjust))
    else $error("frame length adjustment changed by a full-speed function");

  a_fla_hold: assert property (
    !(state.bus == usb_cfg_pkg::BUS_IDLE && bus_req.write) |=>
      $stable(frame_length_adjust))
    else $error("frame length adjustment changed without a write");

  a_fla_read: assert property (
    (s_read_done and (off == usb_cfg_pkg::OFF_USB) and (fn == usb_cfg_pkg::FUNC_HS)) |->
      bus_rsp.readdata[15:8] == {2'b00, $past(state.fla)})
    else $error("frame length adjustment read wrong");

  a_fla_reset: assert property (
    $past(!rst_n) |-> frame_length_adjust == usb_cfg_pkg::FLA_RESET)
    else $error("frame length adjustment reset wrong");

  a_header_read: assert property (
    (s_read_done and (off == usb_cfg_pkg::OFF_HDR)) |->
      bus_rsp.readdata[23:16] == usb_cfg_pkg::HDR_TYPE)
    else $error("header type wrong");

  a_unmapped_read: assert property (
    (bus_req.read && !bus_rsp.waitrequest && !fn_ok) |-> bus_rsp.readdata == '0)
    else $error("unmapped function read not zero");

endmodule : usb_host_config_header_regs

// ### rtl/usb_cfg_pkg.sv
// constants and carrier types shared by the usb host configuration header logic
package usb_cfg_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int FUNC_MSB = 9;
  localparam int FUNC_LSB = 8;
  localparam int OFF_MSB = 7;
  localparam int WORD_LSB = 2;
  localparam int NUM_FUNC = 3;
  localparam logic [1:0] FUNC_HS = 2'h2;

  // ==========================================================
  // register offsets within one function's header
  localparam logic [7:0] OFF_HDR = 8'h0c;
  localparam logic [7:0] OFF_SUBSYS = 8'h2c;
  localparam logic [7:0] OFF_CAP = 8'h34;
  localparam logic [7:0] OFF_IRQ = 8'h3c;
  localparam logic [7:0] OFF_USB = 8'h60;

  // ==========================================================
  // field positions and byte lanes
  localparam int HDR_LSB = 16;
  localparam int SUBSYS_LSB = 16;
  localparam int PIN_LSB = 8;
  localparam int FLA_LSB = 8;
  localparam int FLA_W = 6;
  localparam int BE_LINE = 0;
  localparam int BE_FLA = 1;

  // ==========================================================
  // reset values and fixed codes
  // subsystem identifiers: arbitrary neutral values
  localparam logic [15:0] SUBSYS_FS_RESET = 16'h5a01;
  localparam logic [15:0] SUBSYS_HS_RESET = 16'h5a02;
  localparam logic [7:0] CAP_RESET = 8'h80;
  localparam logic [7:0] IRQ_LINE_RESET = 8'h00;
  localparam logic [7:0] PIN_BASE = 8'h01;
  localparam logic [7:0] HDR_TYPE = 8'h80;
  localparam logic [7:0] USB_REL = 8'h20;
  localparam logic [5:0] FLA_RESET = 6'h20;

  // ==========================================================
  // start-of-frame counter
  localparam int SOF_W = 16;
  localparam logic [15:0] SOF_BASE = 16'he860;
  localparam int SOF_STEP_LSB = 4;

  // ==========================================================
  // carrier types
  typedef enum logic [1:0] {
    BUS_LOAD = 2'b00,
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_type;

  typedef enum logic {
    STRAP_SUBSYS = 1'b0,
    STRAP_CAP = 1'b1
  } strap_field_type;

  typedef struct packed {
    logic valid;
    logic [1:0] func;
    strap_field_type field;
    logic [15:0] data;
  } strap_load_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [BE_W-1:0] byteenable;
    logic [DATA_W-1:0] writedata;
  } avalon_req_type;

  typedef struct packed {
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
  } avalon_rsp_type;

endpackage : usb_cfg_pkg

// ### rtl/sof_period_counter.sv
// start-of-frame period counter driven by the frame length adjustment field
`timescale 1ns/10ps
module sof_period_counter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // period control
  input wire logic [5:0] frame_adjust,
  // frame marker
  output logic sof
);

  typedef struct packed {
    logic [usb_cfg_pkg::SOF_W-1:0] count;
    logic sof;
  } sof_state_type;

  sof_state_type state;
  sof_state_type next_state;
  logic [usb_cfg_pkg::SOF_W-1:0] period_last;

  // ==========================================================
  // counting
  // a lowered adjustment mid-frame ends the frame at once rather than wrapping
  always_comb begin
    // each adjustment step is worth 16 counter clocks, so the reset value lands on 60000
    period_last = usb_cfg_pkg::SOF_BASE +
                  (16'(frame_adjust) << usb_cfg_pkg::SOF_STEP_LSB) - 16'h0001;
    next_state = state;
    if (state.count >= period_last) begin
      next_state.count = '0;
      next_state.sof = 1'b1;
    end else begin
      next_state.count = state.count + 16'h0001;
      next_state.sof = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sof = state.sof;

  // ==========================================================
  // checks
  a_sof_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sof |=> (!sof) [*8])
    else $error("sof pulses too close together");

  a_sof_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sof && $stable(frame_adjust)) |-> ($past(state.count) == period_last))
    else $error("sof period differs from base plus adjustment");

endmodule : sof_period_counter

// ### dv/strap_loader_model.sv
// behavioural strap default loader that feeds override values after each reset
`timescale 1ns/10ps
module strap_loader_model #(
  parameter int GAP = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // strap side
  output usb_cfg_pkg::strap_load_type strap,
  output logic strap_done
);
  // ==========================================================
  // load list
  // the function 3 entry is sent on purpose: the block must drop it
  localparam int N = 3;
  usb_cfg_pkg::strap_load_type load_list [N];
  int idx;
  int gap_count;
  logic [15:0] last;

  initial begin
    load_list[0] = {1'h1, 2'h0, usb_cfg_pkg::STRAP_SUBSYS, 16'h3c1d};
    load_list[1] = {1'h1, 2'h2, usb_cfg_pkg::STRAP_CAP, 16'h0050};
    load_list[2] = {1'h1, 2'h3, usb_cfg_pkg::STRAP_CAP, 16'h0011};
    strap = '0;
    strap_done = 1'h0;
    last = 16'h0;
  end

  // ==========================================================
  // sequencer
  // between loads the data lines flip, so a stale value never looks valid
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      idx <= 0;
      gap_count <= 0;
      strap.valid <= 1'h0;
      strap_done <= 1'h0;
    end else if (idx < N) begin
      if (gap_count < GAP) begin
        gap_count <= gap_count + 1;
        strap.valid <= 1'h0;
        strap.data <= ~last;
      end else begin
        strap <= load_list[idx];
        last <= load_list[idx].data;
        idx <= idx + 1;
        gap_count <= 0;
      end
    end else begin
      strap.valid <= 1'h0;
      strap.data <= ~last;
      strap_done <= 1'h1;
    end
  end
endmodule : strap_loader_model

// ### dv/tb.sv
// self-checking bench for the usb host configuration header registers
`timescale 1ns/10ps
module tb;
  // ==========================================================
  // signals
  typedef struct {
    logic wr;
    logic [9:0] a;
    logic [3:0] be;
    logic [31:0] d;
    logic [31:0] x;
  } row_type;
  localparam int LIMIT = 70000;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  usb_cfg_pkg::avalon_req_type bus_req = '0;
  usb_cfg_pkg::avalon_rsp_type bus_rsp;
  usb_cfg_pkg::strap_load_type strap;
  logic strap_done;
  logic sof_strobe;
  logic [5:0] frame_length_adjust;
  int err_total = 0;
  int checks = 0;
  int ticks = 0;
  int cyc = 0;
  logic [31:0] rd;
  row_type rows [21];

  always #20 ref_clk = ~ref_clk;

  usb_host_config_header_regs dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .strap(strap), .strap_done(strap_done), .sof_strobe(sof_strobe),
    .frame_length_adjust(frame_length_adjust));

  strap_loader_model #(.GAP(5)) loader (
    .ref_clk(ref_clk), .rst_n(rst_n), .strap(strap), .strap_done(strap_done));

  // ==========================================================
  // tasks
  task automatic close_out();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h want %h", $time, got, exp);
    end
  endtask : check

  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    bus_req.read <= !wr;
    bus_req.write <= wr;
    bus_req.address <= a;
    bus_req.byteenable <= be;
    bus_req.writedata <= d;
    do @(posedge ref_clk); while (bus_rsp.waitrequest !== 1'h0);
    r = bus_rsp.readdata;
    bus_req.read <= 1'h0;
    bus_req.write <= 1'h0;
  endtask : bus

  // ==========================================================
  // timeout and cycle count since release
  always @(posedge ref_clk) begin
    ticks <= ticks + 1;
    cyc <= rst_n ? cyc + 1 : 0;
    if (ticks == LIMIT) begin
      err_total++;
      close_out();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    rows = '{
      '{1'h0, 10'h00c, 4'hf, 32'h0, 32'h00800000},
      '{1'h0, 10'h12c, 4'hf, 32'h0, 32'h5a010000},
      '{1'h0, 10'h22c, 4'hf, 32'h0, 32'h5a020000},
      '{1'h1, 10'h22c, 4'hf, 32'hffffffff, 32'h0},
      '{1'h0, 10'h22c, 4'hf, 32'h0, 32'h5a020000},
      '{1'h0, 10'h034, 4'hf, 32'h0, 32'h00000080},
      '{1'h0, 10'h234, 4'hf, 32'h0, 32'h00000050},
      '{1'h0, 10'h334, 4'hf, 32'h0, 32'h0},
      '{1'h0, 10'h03c, 4'hf, 32'h0, 32'h00000100},
      '{1'h0, 10'h13c, 4'hf, 32'h0, 32'h00000200},
      '{1'h0, 10'h23c, 4'hf, 32'h0, 32'h00000300},
      '{1'h0, 10'h260, 4'hf, 32'h0, 32'h00002020},
      '{1'h0, 10'h060, 4'hf, 32'h0, 32'h0},
      '{1'h1, 10'h03c, 4'h1, 32'hffffffa5, 32'h0},
      '{1'h0, 10'h03c, 4'hf, 32'h0, 32'h000001a5},
      '{1'h1, 10'h13c, 4'he, 32'hffffff77, 32'h0},
      '{1'h0, 10'h13c, 4'hf, 32'h0, 32'h00000200},
      '{1'h1, 10'h260, 4'hf, 32'hffffffff, 32'h0},
      '{1'h0, 10'h260, 4'hf, 32'h0, 32'h00003f20},
      '{1'h1, 10'h060, 4'h2, 32'h00000500, 32'h0},
      '{1'h0, 10'h260, 4'hf, 32'h0, 32'h00003f20}
    };
    @(posedge ref_clk);
    @(negedge ref_clk);
    check({31'h0, bus_rsp.waitrequest}, 32'h1);
    check({26'h0, frame_length_adjust}, 32'h20);
    @(posedge ref_clk);
    rst_n <= 1'h1;
    // first access right after release must stall until the loads are in
    bus(1'h0, 10'h02c, 4'hf, 32'h0, rd);
    check(rd, 32'h3c1d0000);
    check({31'h0, strap_done}, 32'h1);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].be, rows[i].d, rd);
      check(rd, rows[i].x);
    end
    check({26'h0, frame_length_adjust}, 32'h3f);
    // second reset in mid-run brings the writable bytes back
    @(posedge ref_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    bus(1'h0, 10'h03c, 4'hf, 32'h0, rd);
    check(rd, 32'h00000100);
    bus(1'h0, 10'h260, 4'hf, 32'h0, rd);
    check(rd, 32'h00002020);
    bus(1'h1, 10'h260, 4'h2, 32'h00003f00, rd);
    check({26'h0, frame_length_adjust}, 32'h3f);
    // period counts 16 per step; release edge is taken with one cycle of slack
    do @(negedge ref_clk); while (sof_strobe !== 1'h1);
    if (cyc < 60495 || cyc > 60497) begin
      err_total++;
      $display("ERROR t=%0t frame marker after %0d cycles", $time, cyc);
    end
    checks++;
    close_out();
  end
endmodule : tb
